/* inc/src_pkg.sv */
// package for the system reset controller: source codes, defaults, timing
package src_pkg;

  // number of reset request sources
  localparam int SRC_NUM_SRC = 8;

  // source bit positions inside the request vector
  localparam int SRC_BIT_POR = 0;
  localparam int SRC_BIT_PIN = 1;
  localparam int SRC_BIT_CMP = 2;
  localparam int SRC_BIT_SW = 3;
  localparam int SRC_BIT_VMON = 4;
  localparam int SRC_BIT_WDT = 5;
  localparam int SRC_BIT_MCD = 6;
  localparam int SRC_BIT_FLASH = 7;

  // port defaults
  localparam int SRC_PORT_W = 8;
  localparam logic [SRC_PORT_W-1:0] SRC_PORT_LATCH_RST = 8'hFF;

  // restart state
  localparam logic [15:0] SRC_RESET_VECTOR = 16'h0000;
  localparam logic SRC_CLKSEL_INTOSC = 1'b0;

  // minimum time the reset state holds after the last request drops
  localparam int SRC_HOLD_NS = 200;
  localparam int SRC_CLK_PERIOD_NS = 100;
  localparam int SRC_HOLD_CYC = (SRC_HOLD_NS + SRC_CLK_PERIOD_NS - 1)
                                / SRC_CLK_PERIOD_NS;
  localparam int SRC_CNT_W = 4;

  typedef enum logic [1:0] {
    SRC_ST_RUN,
    SRC_ST_RESET,
    SRC_ST_HOLD
  } src_state_e;

  // grouped port control outputs
  typedef struct packed {
    logic [SRC_PORT_W-1:0] latch;
    logic openDrain;
    logic weakPullup;
  } src_port_ctl_s;

  // whole state of the controller
  typedef struct packed {
    src_state_e state;
    logic [SRC_CNT_W-1:0] holdCnt;
    logic [SRC_NUM_SRC-1:0] cause;
    logic pwrRelated;
    logic coreHalt;
    logic regInit;
    logic regInitPor;
    logic intTmrOff;
    logic pinDriveLow;
    logic retainHold;
    logic [15:0] pc;
    logic clkSel;
    logic wdtEnable;
    src_port_ctl_s portCtl;
  } src_state_s;

endpackage : src_pkg

/* verilog/src_system_reset_controller.sv */
// system reset controller: merges eight reset requests into one reset state
// Operation
// - While in reset the core is halted and runs no instructions.
// - Reset entry initialises module registers, power-on-only bits only on power-on.
// - During reset the port pins are forced to a known state.
// - Reset entry disables all interrupts and timers.
// - No reset touches data memory contents.
// - Port latches reset to 1, open-drain, weak pull-ups on during and after reset.
// - With retention on, ports, DACs and reference hold through non power-on resets.
// - For supply-monitor and power-on resets the reset pin is driven low until exit.
// - On exit the program counter clears and the clock returns to the internal oscillator.
// - On exit the watchdog is enabled and fetch starts at address 0x0000.
// - Any of the eight sources enters the reset state.
`timescale 1ns/1ns
`default_nettype none
module src_system_reset_controller
  import src_pkg::*;
#(
  parameter int HOLD_CYC = SRC_HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [SRC_NUM_SRC-1:0] resetReq,
  input wire logic retainEn,
  input wire logic ext_reset_pin_n_in,
  output logic ext_reset_pin_n_out,
  output logic ext_reset_pin_n_oe,
  output logic coreHalt,
  output logic regInit,
  output logic regInitPor,
  output logic intTmrDisable,
  output logic retainHold,
  output logic [SRC_PORT_W-1:0] portLatch,
  output logic portOpenDrain,
  output logic portWeakPullup,
  output logic [15:0] pcLoad,
  output logic clkSel,
  output logic wdtEnable,
  output logic [SRC_NUM_SRC-1:0] resetCause
);

  src_state_s st_r;
  src_state_s st_nxt;
  logic [SRC_NUM_SRC-1:0] reqAll;

  // pin level folds in as the external source; a driven-low pin we drive
  // ourselves must not re-trigger reset, so it is masked while we drive
  function automatic logic [SRC_NUM_SRC-1:0] mergeReq(
    input logic [SRC_NUM_SRC-1:0] req,
    input logic pinN,
    input logic selfDrive
  );
    logic [SRC_NUM_SRC-1:0] m;
    m = req;
    m[SRC_BIT_PIN] = req[SRC_BIT_PIN] | (~pinN & ~selfDrive);
    return m;
  endfunction : mergeReq

  always_comb begin
    reqAll = mergeReq(resetReq, ext_reset_pin_n_in, st_r.pinDriveLow);
    st_nxt = st_r;
    case (st_r.state)
      SRC_ST_RUN: begin
        if (|reqAll) begin
          st_nxt.state = SRC_ST_RESET;
          st_nxt.cause = reqAll;
          st_nxt.pwrRelated = reqAll[SRC_BIT_POR] | reqAll[SRC_BIT_VMON];
          st_nxt.coreHalt = 1'b1;
          st_nxt.regInit = 1'b1;
          st_nxt.regInitPor = reqAll[SRC_BIT_POR];
          st_nxt.intTmrOff = 1'b1;
          st_nxt.pinDriveLow = reqAll[SRC_BIT_POR] | reqAll[SRC_BIT_VMON];
          st_nxt.retainHold = retainEn & ~reqAll[SRC_BIT_POR];
          if (!(retainEn && !reqAll[SRC_BIT_POR])) begin
            st_nxt.portCtl.latch = SRC_PORT_LATCH_RST;
            st_nxt.portCtl.openDrain = 1'b1;
            st_nxt.portCtl.weakPullup = 1'b1;
          end
        end
      end
      SRC_ST_RESET: begin
        // later sources are accumulated so a power-on during reset still wins
        st_nxt.cause = st_r.cause | reqAll;
        if (reqAll[SRC_BIT_POR]) begin
          st_nxt.regInitPor = 1'b1;
          st_nxt.retainHold = 1'b0;
          st_nxt.portCtl.latch = SRC_PORT_LATCH_RST;
          st_nxt.portCtl.openDrain = 1'b1;
          st_nxt.portCtl.weakPullup = 1'b1;
        end
        if (reqAll[SRC_BIT_POR] | reqAll[SRC_BIT_VMON]) begin
          st_nxt.pinDriveLow = 1'b1;
        end
        if (~|reqAll) begin
          st_nxt.state = SRC_ST_HOLD;
          st_nxt.holdCnt = SRC_CNT_W'(HOLD_CYC);
        end
      end
      SRC_ST_HOLD: begin
        if (|reqAll) begin
          st_nxt.state = SRC_ST_RESET;
          st_nxt.cause = st_r.cause | reqAll;
          // a power-on landing in the hold must act now, not a cycle later
          if (reqAll[SRC_BIT_POR]) begin
            st_nxt.regInitPor = 1'b1;
            st_nxt.retainHold = 1'b0;
            st_nxt.portCtl.latch = SRC_PORT_LATCH_RST;
            st_nxt.portCtl.openDrain = 1'b1;
            st_nxt.portCtl.weakPullup = 1'b1;
          end
          if (reqAll[SRC_BIT_POR] | reqAll[SRC_BIT_VMON]) begin
            st_nxt.pinDriveLow = 1'b1;
          end
        end else if (st_r.holdCnt <= SRC_CNT_W'(1)) begin
          st_nxt.state = SRC_ST_RUN;
          st_nxt.coreHalt = 1'b0;
          st_nxt.regInit = 1'b0;
          st_nxt.regInitPor = 1'b0;
          st_nxt.intTmrOff = 1'b0;
          st_nxt.pinDriveLow = 1'b0;
          st_nxt.pc = SRC_RESET_VECTOR;
          st_nxt.clkSel = SRC_CLKSEL_INTOSC;
          st_nxt.wdtEnable = 1'b1;
        end else begin
          st_nxt.holdCnt = st_r.holdCnt - SRC_CNT_W'(1);
        end
      end
      default: begin
        st_nxt.state = SRC_ST_RESET;
      end
    endcase
  end

  // the controller's own reset acts as a power-on: everything defaults
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r.state <= SRC_ST_HOLD;
      st_r.holdCnt <= SRC_CNT_W'(HOLD_CYC);
      st_r.cause <= SRC_NUM_SRC'(1) << SRC_BIT_POR;
      st_r.pwrRelated <= 1'b1;
      st_r.coreHalt <= 1'b1;
      st_r.regInit <= 1'b1;
      st_r.regInitPor <= 1'b1;
      st_r.intTmrOff <= 1'b1;
      st_r.pinDriveLow <= 1'b1;
      st_r.retainHold <= 1'b0;
      st_r.pc <= SRC_RESET_VECTOR;
      st_r.clkSel <= SRC_CLKSEL_INTOSC;
      st_r.wdtEnable <= 1'b1;
      st_r.portCtl.latch <= SRC_PORT_LATCH_RST;
      st_r.portCtl.openDrain <= 1'b1;
      st_r.portCtl.weakPullup <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // data memory has no reset path from here at all: nothing clears it
  assign coreHalt = st_r.coreHalt;
  assign regInit = st_r.regInit;
  assign regInitPor = st_r.regInitPor;
  assign intTmrDisable = st_r.intTmrOff;
  assign retainHold = st_r.retainHold;
  assign portLatch = st_r.portCtl.latch;
  assign portOpenDrain = st_r.portCtl.openDrain;
  assign portWeakPullup = st_r.portCtl.weakPullup;
  assign pcLoad = st_r.pc;
  assign clkSel = st_r.clkSel;
  assign wdtEnable = st_r.wdtEnable;
  assign resetCause = st_r.cause;
  // open-drain: only ever drives low
  assign ext_reset_pin_n_out = 1'b0;
  assign ext_reset_pin_n_oe = st_r.pinDriveLow;

  chk_req_enters_reset: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && |reqAll) |=> coreHalt && regInit)
    else $error("reset request did not enter reset");

  chk_halt_while_req: assert property (
    @(posedge core_clk) disable iff (reset)
    (|resetReq) |=> coreHalt)
    else $error("core ran while a reset request was present");

  chk_por_pin_low: assert property (
    @(posedge core_clk) disable iff (reset)
    resetReq[SRC_BIT_POR] |=> ext_reset_pin_n_oe throughout coreHalt[*2])
    else $error("reset pin not driven low for power reset");

  chk_pin_released: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(coreHalt) |-> !ext_reset_pin_n_oe)
    else $error("reset pin still driven after exit");

  chk_release_time: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RESET && reqAll == '0) ##1 (reqAll == '0)[*2]
    |-> ##1 !coreHalt)
    else $error("reset not released after last request");

  chk_exit_defaults: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(coreHalt) |-> pcLoad == SRC_RESET_VECTOR
                        && clkSel == SRC_CLKSEL_INTOSC && wdtEnable)
    else $error("restart defaults wrong on exit");

  chk_port_default: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && !retainEn && |reqAll) |=>
      portLatch == SRC_PORT_LATCH_RST && portOpenDrain && portWeakPullup)
    else $error("port defaults not applied");

  chk_retain_por: assert property (
    @(posedge core_clk) disable iff (reset)
    reqAll[SRC_BIT_POR] |=> !retainHold && regInitPor)
    else $error("retention kept through power-on reset");

  chk_cause_kept: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && |reqAll) |=> (resetCause == $past(reqAll)))
    else $error("reset cause not recorded");

  chk_int_off: assert property (
    @(posedge core_clk) disable iff (reset)
    coreHalt |-> intTmrDisable)
    else $error("interrupts enabled during reset");

  chk_halt_not_run: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state != SRC_ST_RUN) |-> coreHalt)
    else $error("core not halted outside run state");

  chk_run_no_halt: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN) |-> !coreHalt)
    else $error("core halted in run state");

  chk_init_in_reset: assert property (
    @(posedge core_clk) disable iff (reset)
    coreHalt |-> regInit)
    else $error("register init missing during reset");

  chk_por_init: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && reqAll[SRC_BIT_POR]) |=> regInitPor)
    else $error("power-on bits not initialised");

  chk_nonpor_keep: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && |reqAll && !reqAll[SRC_BIT_POR])
    |=> !regInitPor)
    else $error("power-on bits cleared by other reset");

  chk_port_known: assert property (
    @(posedge core_clk) disable iff (reset)
    (coreHalt && !retainHold) |-> portLatch == SRC_PORT_LATCH_RST)
    else $error("port latch not in known state");

  chk_int_entry: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && |reqAll) |=> intTmrDisable)
    else $error("interrupts not disabled on entry");

  chk_retain_entry: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && |reqAll && retainEn
     && !reqAll[SRC_BIT_POR]) |=> retainHold)
    else $error("retention not held through reset");

  chk_vmon_pin_low: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && reqAll[SRC_BIT_VMON])
    |=> ext_reset_pin_n_oe)
    else $error("reset pin not driven for supply reset");

  chk_pin_power_only: assert property (
    @(posedge core_clk) disable iff (reset)
    ext_reset_pin_n_oe |->
      (resetCause[SRC_BIT_POR] || resetCause[SRC_BIT_VMON]))
    else $error("reset pin driven for non-power reset");

  chk_self_drive_masked: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RESET && ext_reset_pin_n_oe && resetReq == '0)
    |=> st_r.state == SRC_ST_HOLD)
    else $error("own pin drive held the reset");

  chk_exit_clean: assert property (
    @(posedge core_clk) disable iff (reset)
    $fell(coreHalt) |-> !intTmrDisable && !regInit)
    else $error("init or disable left on after exit");

  chk_hold_reenter: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_HOLD && |reqAll) |=> st_r.state == SRC_ST_RESET)
    else $error("request in hold did not re-enter reset");

  chk_no_early_exit: assert property (
    @(posedge core_clk) disable iff (reset)
    (|reqAll) |=> coreHalt ##1 coreHalt)
    else $error("reset released too early");

  chk_cause_set: assert property (
    @(posedge core_clk) disable iff (reset)
    coreHalt |-> resetCause != '0)
    else $error("reset cause empty during reset");

  chk_cause_stable: assert property (
    @(posedge core_clk) disable iff (reset)
    (st_r.state == SRC_ST_RUN && reqAll == '0) |=> $stable(resetCause))
    else $error("reset cause changed while running");

  chk_wdt_on_run: assert property (
    @(posedge core_clk) disable iff (reset)
    !coreHalt |-> wdtEnable)
    else $error("watchdog off after reset");

  chk_clk_on_run: assert property (
    @(posedge core_clk) disable iff (reset)
    !coreHalt |-> clkSel == SRC_CLKSEL_INTOSC)
    else $error("clock not internal after reset");

endmodule : src_system_reset_controller
`default_nettype wire

/* bench/src_reset_src_model.sv */
// model of the reset sources and the open-drain reset pin
`timescale 1ns/1ns
`default_nettype none
module src_reset_src_model
  import src_pkg::*;
(
  input wire logic [SRC_NUM_SRC-1:0] reqCmd,
  input wire logic pressCmd,
  input wire logic pinOe,
  input wire logic pinOut,
  output logic [SRC_NUM_SRC-1:0] resetReq,
  output logic pinLevel
);
  assign resetReq = reqCmd;
  // pulled up: the wire is low only while the device or a button pulls it
  assign pinLevel = ~((pinOe & ~pinOut) | pressCmd);
endmodule : src_reset_src_model
`default_nettype wire

/* bench/test_system_reset_controller.sv */
// self-checking testbench for the system reset controller
`timescale 1ns/1ns
`default_nettype none
module test_system_reset_controller
  import src_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reqCmd = 8'h00;
  logic pressCmd = 1'b0;
  logic retainEn = 1'b0;
  logic [7:0] resetReq, portLatch, resetCause;
  logic [15:0] pcLoad;
  logic pinLevel, pinOut, pinOe, coreHalt, regInit, regInitPor, intTmrDis;
  logic retainHold, portOd, portWpu, clkSel, wdtEnable;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  src_system_reset_controller i_dut (.core_clk(clk), .reset(rst),
    .resetReq(resetReq), .retainEn(retainEn),
    .ext_reset_pin_n_in(pinLevel), .ext_reset_pin_n_out(pinOut),
    .ext_reset_pin_n_oe(pinOe), .coreHalt(coreHalt), .regInit(regInit),
    .regInitPor(regInitPor), .intTmrDisable(intTmrDis),
    .retainHold(retainHold), .portLatch(portLatch),
    .portOpenDrain(portOd), .portWeakPullup(portWpu), .pcLoad(pcLoad),
    .clkSel(clkSel), .wdtEnable(wdtEnable), .resetCause(resetCause));
  src_reset_src_model i_src (.reqCmd(reqCmd), .pressCmd(pressCmd),
    .pinOe(pinOe), .pinOut(pinOut), .resetReq(resetReq),
    .pinLevel(pinLevel));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic drive(input logic [7:0] v);
    @(posedge clk);
    reqCmd <= v;
    #1;
  endtask : drive

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // bounded wait for the core to run again, then the restart state
  task automatic expect_run(input logic [7:0] cause);
    int k;
    k = 0;
    while (coreHalt !== 1'b0 && k < 12) begin
      tick(1);
      k++;
    end
    chk(coreHalt, 1'b0);
    chk(pcLoad, SRC_RESET_VECTOR);
    chk(clkSel, SRC_CLKSEL_INTOSC);
    chk(wdtEnable, 1'b1);
    chk({regInit, intTmrDis, pinOe, pinLevel}, 4'h1);
    chk({portLatch, portOd, portWpu}, {SRC_PORT_LATCH_RST, 2'b11});
    chk(resetCause, cause);
  endtask : expect_run

  task automatic t_source(input int i);
    logic [7:0] m;
    m = 8'h01 << i;
    drive(m);
    tick(6);
    chk({coreHalt, regInit, intTmrDis}, 3'h7);
    chk(regInitPor, i == SRC_BIT_POR);
    chk(pinOe, i == SRC_BIT_POR || i == SRC_BIT_VMON);
    chk(pinLevel, !(i == SRC_BIT_POR || i == SRC_BIT_VMON));
    chk({portLatch, portOd, portWpu}, {SRC_PORT_LATCH_RST, 2'b11});
    drive(8'h00);
    expect_run(m);
  endtask : t_source

  task automatic t_overlap();
    drive(8'h20);
    tick(2);
    drive(8'h28);
    tick(2);
    drive(8'h08);
    tick(5);
    chk(coreHalt, 1'b1);
    drive(8'h00);
    expect_run(8'h28);
  endtask : t_overlap

  task automatic t_pin();
    @(posedge clk);
    pressCmd <= 1'b1;
    tick(5);
    chk({coreHalt, pinOe}, 2'b10);
    @(posedge clk);
    pressCmd <= 1'b0;
    expect_run(8'h02);
  endtask : t_pin

  // retention holds through a watchdog reset but never through power-on
  task automatic t_retain();
    @(posedge clk);
    retainEn <= 1'b1;
    drive(8'h20);
    tick(4);
    chk(retainHold, 1'b1);
    drive(8'h00);
    expect_run(8'h20);
    drive(8'h01);
    tick(4);
    chk(retainHold, 1'b0);
    drive(8'h00);
    expect_run(8'h01);
    @(posedge clk);
    retainEn <= 1'b0;
  endtask : t_retain

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1500) begin
      n_fail++;
      $display("ERROR %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  initial begin
    tick(8);
    chk({coreHalt, regInitPor, pinOe, pinLevel}, 4'hE);
    repeat (7) @(posedge clk);
    rst <= 1'b0;
    #1;
    expect_run(8'h01);
    for (int i = 0; i < SRC_NUM_SRC; i++) begin
      t_source(i);
    end
    t_overlap();
    t_pin();
    t_retain();
    report_and_stop();
  end
endmodule : test_system_reset_controller
`default_nettype wire
